// ### hw/xbc_pkg.sv
package xbc_pkg;

  localparam int XBC_ADDR_W = 20;
  localparam int XBC_DATA_W = 16;
  localparam int XBC_AREA_N = 4;
  localparam int XBC_SYNC_STAGES = 2;

  // Idle levels of the bus pins after reset.
  localparam logic XBC_STROBE_RST = 1'b1;
  localparam logic XBC_GRANT_RST = 1'b1;
  localparam logic XBC_ALE_RST = 1'b0;
  localparam logic [XBC_AREA_N-1:0] XBC_AREA_RST = 4'hf;
  localparam logic [XBC_ADDR_W-1:0] XBC_ADDR_RST = 20'h0_0000;
  localparam logic [XBC_DATA_W-1:0] XBC_DATA_RST = 16'h0000;

  // Bus clock is the system clock divided by two: one phase per system cycle.
  localparam logic XBC_PHASE_RST = 1'b0;

  typedef enum logic [1:0] {
    XBC_ST_IDLE,
    XBC_ST_ADDR,
    XBC_ST_STROBE,
    XBC_ST_HOLD
  } xbc_state_t;

  typedef struct packed {
    logic single_strobe;
    logic bus16;
    logic muxed;
  } xbc_cfg_t;

  typedef struct packed {
    logic write;
    logic word;
    logic [1:0] area;
    logic [XBC_ADDR_W-1:0] addr;
    logic [XBC_DATA_W-1:0] wdata;
  } xbc_req_t;

  typedef struct packed {
    logic [XBC_ADDR_W-1:0] addr;
    logic addr_oe;
    logic [XBC_DATA_W-1:0] dout;
    logic dout_oe;
    logic ctrl_oe;
    logic addr_latch;
    logic load_strobe_n;
    logic store_strobe_low_byte_n;
    logic store_strobe_high_byte_n;
    logic [XBC_AREA_N-1:0] area_select_n;
  } xbc_bus_t;

endpackage

// ### hw/xbc_sync.sv
`timescale 1ns/1ps
module xbc_sync
  import xbc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = ce_i ? async_i : meta_reg;
    sync_next = ce_i ? meta_reg : sync_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule

// ### hw/xbc_bclk_gen.sv
`timescale 1ns/1ps
module xbc_bclk_gen
  import xbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  output logic bclk_o,
  output logic tick_o
);

  logic phase_reg;
  logic phase_next;

  always_comb begin
    phase_next = ce_i ? ~phase_reg : phase_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      phase_reg <= XBC_PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Bus pins update on the edge where the bus clock rises, so they move with it.
  assign bclk_o = phase_reg;
  assign tick_o = ~phase_reg & ce_i;

endmodule

// ### hw/xbc_ctrl.sv
// Summary of operation
// - With split strobes on a 16-bit bus, a store to an even address pulls the low-byte strobe low.
// - With split strobes on a 16-bit bus, a store to an odd address pulls the high-byte strobe low.
// - With split strobes, the load strobe is low while data is read from the bus.
// - With the single strobe, the store strobe is low for stores and the load strobe for reads.
// - With the single strobe, the upper-byte enable is low whenever an odd address is accessed.
// - The single strobe with upper-byte enable is the scheme meant for a 16-bit data bus.
// - A configuration input picks the scheme, and each pair of strobe pins switches as one.
// - A low release request makes the block enter hold from idle when no request is taken, and stay there while it stays low.
// - In hold the release grant output is driven low.
// - An address latch pulse marks the address phase so outside logic can capture it.
// - While bus ready is low the access is stretched by wait cycles.
// - In 8-bit multiplexed mode the low address byte and the data byte share pins in turn.
// - In 16-bit multiplexed mode address bits 1 to 8 share pins with data 0 to 7, bit 0 apart.
// - Four area-select outputs show which space the current cycle targets.
`timescale 1ns/1ps
module xbc_ctrl
  import xbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire xbc_cfg_t cfg_i,
  input wire logic req_valid_i,
  input wire xbc_req_t req_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic [XBC_DATA_W-1:0] rdata_o,
  output logic bclk_o,
  output xbc_bus_t bus_o,
  input wire logic [XBC_DATA_W-1:0] data_i,
  input wire logic bus_ready_i,
  input wire logic bus_release_req_n_i,
  output logic bus_release_grant_n_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock and input synchronisers.

  logic tick;
  logic bclk_int;
  logic ready_s;
  logic release_req_n_s;
  logic [XBC_DATA_W-1:0] data_s;

  xbc_bclk_gen u_bclk (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .bclk_o(bclk_int),
    .tick_o(tick)
  );

  xbc_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_sync_ctl (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i({bus_ready_i, bus_release_req_n_i}),
    .sync_o({ready_s, release_req_n_s})
  );

  xbc_sync #(.WIDTH(XBC_DATA_W), .RST_VAL(XBC_DATA_RST)) u_sync_data (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(data_i),
    .sync_o(data_s)
  );

  assign bclk_o = bclk_int;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  xbc_state_t state_reg;
  xbc_state_t state_next;
  xbc_req_t cur_reg;
  xbc_req_t cur_next;
  xbc_bus_t bus_reg;
  xbc_bus_t bus_next;
  logic grant_n_reg;
  logic grant_n_next;
  logic ready_reg;
  logic ready_next;
  logic resp_reg;
  logic resp_next;
  logic cap_reg;
  logic cap_next;
  logic [XBC_DATA_W-1:0] rdata_reg;
  logic [XBC_DATA_W-1:0] rdata_next;

  logic lo_lane;
  logic hi_lane;
  logic [XBC_DATA_W-1:0] wdata_lanes;
  logic [XBC_DATA_W-1:0] rdata_lanes;
  logic [7:0] mux_addr;
  logic taken;

  always_comb begin
    // On an 8-bit bus every byte travels on the low lane.
    lo_lane = !cfg_i.bus16 || cur_reg.word || !cur_reg.addr[0];
    hi_lane = cfg_i.bus16 && (cur_reg.word || cur_reg.addr[0]);
    wdata_lanes = XBC_DATA_RST;
    if (!cfg_i.bus16) begin
      wdata_lanes[7:0] = cur_reg.wdata[7:0];
    end else if (!cur_reg.word && cur_reg.addr[0]) begin
      wdata_lanes[15:8] = cur_reg.wdata[7:0];
    end else begin
      wdata_lanes = cur_reg.wdata;
    end
    rdata_lanes = XBC_DATA_RST;
    if (cfg_i.bus16 && cur_reg.word) begin
      rdata_lanes = data_s;
    end else if (cfg_i.bus16 && cur_reg.addr[0]) begin
      rdata_lanes[7:0] = data_s[15:8];
    end else begin
      rdata_lanes[7:0] = data_s[7:0];
    end
    mux_addr = cfg_i.bus16 ? cur_next.addr[8:1] : cur_next.addr[7:0];
  end

  assign taken = req_valid_i && ready_reg;

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    bus_next = bus_reg;
    grant_n_next = grant_n_reg;
    resp_next = ce_i ? 1'b0 : resp_reg;
    cap_next = ce_i ? 1'b0 : cap_reg;
    rdata_next = rdata_reg;
    if (tick) begin
      case (state_reg)
        XBC_ST_IDLE: begin
          if (taken) begin
            cur_next = req_i;
            state_next = XBC_ST_ADDR;
          end else if (!release_req_n_s) begin
            state_next = XBC_ST_HOLD;
          end
        end
        XBC_ST_ADDR: begin
          state_next = XBC_ST_STROBE;
        end
        XBC_ST_STROBE: begin
          if (ready_s) begin
            state_next = XBC_ST_IDLE;
            cap_next = 1'b1;
          end
        end
        XBC_ST_HOLD: begin
          if (release_req_n_s) begin
            state_next = XBC_ST_IDLE;
          end
        end
        default: begin
          state_next = XBC_ST_IDLE;
        end
      endcase

      // Pin values for the state being entered.
      bus_next.addr_latch = 1'b0;
      bus_next.load_strobe_n = XBC_STROBE_RST;
      bus_next.store_strobe_low_byte_n = XBC_STROBE_RST;
      bus_next.store_strobe_high_byte_n = XBC_STROBE_RST;
      bus_next.area_select_n = XBC_AREA_RST;
      bus_next.dout_oe = 1'b0;
      bus_next.ctrl_oe = 1'b1;
      bus_next.addr_oe = 1'b1;
      grant_n_next = 1'b1;
      case (state_next)
        XBC_ST_ADDR: begin
          bus_next.addr = cur_next.addr;
          bus_next.addr_latch = 1'b1;
          bus_next.area_select_n[cur_next.area] = 1'b0;
          if (cfg_i.muxed) begin
            bus_next.dout = XBC_DATA_RST;
            bus_next.dout[7:0] = mux_addr;
            bus_next.dout_oe = 1'b1;
          end
          if (cfg_i.single_strobe) begin
            bus_next.store_strobe_high_byte_n = !(cur_next.addr[0] ||
              (cfg_i.bus16 && cur_next.word));
          end
        end
        XBC_ST_STROBE: begin
          bus_next.area_select_n[cur_reg.area] = 1'b0;
          bus_next.dout = wdata_lanes;
          bus_next.dout_oe = cur_reg.write;
          bus_next.load_strobe_n = cur_reg.write;
          if (cfg_i.single_strobe) begin
            bus_next.store_strobe_low_byte_n = !cur_reg.write;
            bus_next.store_strobe_high_byte_n = !(cur_reg.addr[0] ||
              (cfg_i.bus16 && cur_reg.word));
          end else begin
            bus_next.store_strobe_low_byte_n = !(cur_reg.write && lo_lane);
            bus_next.store_strobe_high_byte_n = !(cur_reg.write && hi_lane);
          end
        end
        XBC_ST_HOLD: begin
          bus_next.ctrl_oe = 1'b0;
          bus_next.addr_oe = 1'b0;
          grant_n_next = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // Read data arrives through the two-stage synchroniser, so it is taken one cycle
    // after the strobe ends; the response waits for it so that data and pulse agree.
    if (ce_i && cap_reg) begin
      resp_next = 1'b1;
      if (!cur_reg.write) begin
        rdata_next = rdata_lanes;
      end
    end
    // A request can only be taken on the next tick, so ready rises one cycle ahead.
    ready_next = ce_i ? (state_next == XBC_ST_IDLE) && !tick : ready_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= XBC_ST_IDLE;
      cur_reg <= '0;
      bus_reg.addr <= XBC_ADDR_RST;
      bus_reg.addr_oe <= 1'b1;
      bus_reg.dout <= XBC_DATA_RST;
      bus_reg.dout_oe <= 1'b0;
      bus_reg.ctrl_oe <= 1'b1;
      bus_reg.addr_latch <= XBC_ALE_RST;
      bus_reg.load_strobe_n <= XBC_STROBE_RST;
      bus_reg.store_strobe_low_byte_n <= XBC_STROBE_RST;
      bus_reg.store_strobe_high_byte_n <= XBC_STROBE_RST;
      bus_reg.area_select_n <= XBC_AREA_RST;
      grant_n_reg <= XBC_GRANT_RST;
      ready_reg <= 1'b0;
      resp_reg <= 1'b0;
      cap_reg <= 1'b0;
      rdata_reg <= XBC_DATA_RST;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      bus_reg <= bus_next;
      grant_n_reg <= grant_n_next;
      ready_reg <= ready_next;
      resp_reg <= resp_next;
      cap_reg <= cap_next;
      rdata_reg <= rdata_next;
    end
  end

  assign req_ready_o = ready_reg;
  assign resp_valid_o = resp_reg;
  assign rdata_o = rdata_reg;
  assign bus_o = bus_reg;
  assign bus_release_grant_n_o = grant_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_split_low_store: assert property (
    state_reg == XBC_ST_STROBE && !cfg_i.single_strobe && cfg_i.bus16 && cur_reg.write &&
    !cur_reg.addr[0] && $stable(cfg_i) && $past(tick) |-> !bus_reg.store_strobe_low_byte_n)
    else $error("low-byte strobe not low for even store");

  a_split_high_store: assert property (
    state_reg == XBC_ST_STROBE && !cfg_i.single_strobe && cur_reg.write &&
    !cur_reg.word && cfg_i.bus16 && $stable(cfg_i) && $past(tick) |->
    bus_reg.store_strobe_high_byte_n == !cur_reg.addr[0])
    else $error("high-byte strobe wrong for byte store");

  a_load_strobe: assert property (
    !bus_reg.load_strobe_n |-> state_reg == XBC_ST_STROBE && !cur_reg.write)
    else $error("load strobe low outside a read");

  a_single_store: assert property (
    cfg_i.single_strobe && $stable(cfg_i) && $past(tick) && state_reg == XBC_ST_STROBE |->
    bus_reg.store_strobe_low_byte_n == !cur_reg.write)
    else $error("store strobe wrong in single-strobe scheme");

  a_upper_enable: assert property (
    cfg_i.single_strobe && $stable(cfg_i) && $past(tick) && cur_reg.addr[0] &&
    (state_reg == XBC_ST_ADDR || state_reg == XBC_ST_STROBE) |->
    !bus_reg.store_strobe_high_byte_n)
    else $error("upper-byte enable high on odd access");

  a_hold_grant: assert property (
    tick && state_reg == XBC_ST_IDLE && !taken && !release_req_n_s |=>
    !bus_release_grant_n_o && !bus_o.addr_oe && !bus_o.ctrl_oe)
    else $error("hold entered without grant and release");

  a_hold_stays: assert property (
    state_reg == XBC_ST_HOLD && !release_req_n_s |=> state_reg == XBC_ST_HOLD)
    else $error("hold left while request held");

  a_hold_release: assert property (
    state_reg == XBC_ST_HOLD && $past(tick) |-> !bus_o.dout_oe && !bus_o.ctrl_oe)
    else $error("pins driven during hold");

  a_wait_ready: assert property (
    tick && state_reg == XBC_ST_STROBE && !ready_s |=> state_reg == XBC_ST_STROBE ##1
    state_reg == XBC_ST_STROBE)
    else $error("strobe ended while bus not ready");

  a_ale_phase: assert property (
    $rose(bus_o.addr_latch) |-> state_reg == XBC_ST_ADDR && bclk_o &&
    bus_o.addr == cur_reg.addr ##1 bus_o.addr_latch && tick)
    else $error("address latch pulse misplaced");

  a_area_select: assert property (
    state_reg == XBC_ST_IDLE && $past(tick) |-> bus_o.area_select_n == XBC_AREA_RST)
    else $error("area select active while idle");

  c_read: cover property (resp_valid_o && !cur_reg.write);
  c_write_wait: cover property (tick && state_reg == XBC_ST_STROBE && !ready_s && cur_reg.write);
  c_hold: cover property (state_reg == XBC_ST_HOLD ##1 state_reg == XBC_ST_IDLE);
  c_single_odd: cover property (cfg_i.single_strobe && !bus_o.store_strobe_high_byte_n);

endmodule

// ### verif/xbc_mem_model.sv
`timescale 1ns/1ps
module xbc_mem_model
  import xbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire xbc_cfg_t cfg_i,
  input wire xbc_bus_t bus_i,
  input wire logic [3:0] wait_cnt_i,
  output logic [XBC_DATA_W-1:0] data_o,
  output logic bus_ready_o
);
  logic [7:0] mem [256];
  logic [7:0] addr_reg;
  logic [3:0] stall_reg = 4'h0;
  logic busy_reg = 1'b0;
  logic [XBC_DATA_W-1:0] last_reg = 16'h0000;
  logic wr_lo;
  logic wr_hi;
  logic rd;
  logic busy;

  ////////////////////////////////////////////////////////////////////////////
  // Released strobes float high through the board pull-ups.
  assign wr_lo = bus_i.ctrl_oe && !bus_i.store_strobe_low_byte_n;
  assign wr_hi = bus_i.ctrl_oe && !bus_i.store_strobe_high_byte_n && cfg_i.bus16 &&
                 (!cfg_i.single_strobe || wr_lo);
  assign rd = bus_i.ctrl_oe && !bus_i.load_strobe_n;
  // The controller sees bus ready two cycles late, so a slow device must start its
  // wait from the area select, not from the strobe.
  assign busy = bus_i.ctrl_oe && (bus_i.area_select_n != 4'hf);
  assign bus_ready_o = (stall_reg == 4'h0);
  // An undriven data bus shows a pattern that changes each cycle, never the last value.
  assign data_o = !rd ? ~last_reg :
                  cfg_i.bus16 ? {mem[addr_reg | 8'h01], mem[addr_reg & 8'hfe]} :
                  {~last_reg[15:8], mem[addr_reg]};

  initial begin
    for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'h5a;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    last_reg <= data_o;
    busy_reg <= busy;
    if (bus_i.ctrl_oe && bus_i.addr_latch) begin
      addr_reg <= !cfg_i.muxed ? bus_i.addr[7:0] :
                  cfg_i.bus16 ? {bus_i.dout[6:0], bus_i.addr[0]} : bus_i.dout[7:0];
    end
    if (wr_lo && (!cfg_i.bus16 || !cfg_i.single_strobe || !addr_reg[0])) begin
      mem[cfg_i.bus16 ? (addr_reg & 8'hfe) : addr_reg] <= bus_i.dout[7:0];
    end
    if (wr_hi) begin
      mem[addr_reg | 8'h01] <= bus_i.dout[15:8];
    end
    if (srst_i) begin
      stall_reg <= 4'h0;
    end else if (busy && !busy_reg) begin
      stall_reg <= wait_cnt_i;
    end else if (stall_reg != 4'h0) begin
      stall_reg <= stall_reg - 4'h1;
    end
  end
endmodule

// ### verif/tb_external_bus_control_signals.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_external_bus_control_signals;
  import xbc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  xbc_cfg_t cfg_i = '0;
  logic req_valid_i = 1'b0;
  xbc_req_t req_i = '0;
  logic bus_release_req_n_i = 1'b1;
  logic [3:0] wait_cnt = 4'h0;
  logic req_ready_o;
  logic resp_valid_o;
  logic bus_ready_i;
  logic bus_release_grant_n_o;
  logic [XBC_DATA_W-1:0] rdata_o;
  logic [XBC_DATA_W-1:0] data_i;
  xbc_bus_t bus_o;
  logic [7:0] exp_mem [256];
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 32'h85b2_c59f;

  always #50 sys_clk_i = ~sys_clk_i;

  xbc_ctrl dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1), .cfg_i(cfg_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .resp_valid_o(resp_valid_o), .rdata_o(rdata_o), .bclk_o(), .bus_o(bus_o),
    .data_i(data_i), .bus_ready_i(bus_ready_i), .bus_release_req_n_i(bus_release_req_n_i),
    .bus_release_grant_n_o(bus_release_grant_n_o));

  xbc_mem_model mem_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cfg_i(cfg_i), .bus_i(bus_o),
    .wait_cnt_i(wait_cnt), .data_o(data_i), .bus_ready_o(bus_ready_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bail();
    error_cnt++;
    $display("ERROR t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
    conclude();
  endtask

  task automatic xfer(input logic wr, input logic wd, input logic [1:0] ar,
                      input logic [19:0] ad, input logic [15:0] wv, input logic [3:0] wt);
    int n;
    logic [2:0] seen;
    logic [2:0] exp_s;
    logic ale;
    logic [3:0] area;
    logic [7:0] a;
    a = ad[7:0];
    seen = 3'h0;
    ale = 1'b0;
    area = 4'hf;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: wr, word: wd, area: ar, addr: ad, wdata: wv};
    wait_cnt <= wt;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 50);
    if (req_ready_o !== 1'b1) bail();
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
      seen |= ~{bus_o.store_strobe_low_byte_n, bus_o.store_strobe_high_byte_n,
                bus_o.load_strobe_n};
      if (bus_o.area_select_n !== 4'hf) area = bus_o.area_select_n;
      if (bus_o.addr_latch === 1'b1) begin
        ale = 1'b1;
        if (cfg_i.muxed) `CHK(bus_o.dout[7:0], cfg_i.bus16 ? ad[8:1] : ad[7:0])
      end
    end while (resp_valid_o !== 1'b1 && n < 60);
    if (resp_valid_o !== 1'b1) bail();
    exp_s = cfg_i.single_strobe ? {wr, a[0] | (cfg_i.bus16 & wd), ~wr} :
            {wr & (wd | ~a[0]), wr & (wd | a[0]), ~wr};
    `CHK(seen, exp_s)
    `CHK({ale, area}, {1'b1, ~(4'h1 << ar)})
    if (wt == 4'h0) `CHK(n, 6)
    if (wt >= 4'h4) `CHK(n > 5, 1'b1)
    if (wr && wd) begin
      exp_mem[a & 8'hfe] = wv[7:0];
      exp_mem[a | 8'h01] = wv[15:8];
    end else if (wr) begin
      exp_mem[a] = wv[7:0];
    end else if (wd) begin
      `CHK(rdata_o, {exp_mem[a | 8'h01], exp_mem[a & 8'hfe]})
    end else begin
      `CHK(rdata_o[7:0], exp_mem[a])
    end
  endtask

  task automatic hold_test();
    int n;
    @(posedge sys_clk_i);
    bus_release_req_n_i <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (bus_release_grant_n_o !== 1'b0 && n < 20);
    if (bus_release_grant_n_o !== 1'b0) bail();
    repeat (8) begin
      @(negedge sys_clk_i);
      `CHK({bus_release_grant_n_o, bus_o.addr_oe, bus_o.dout_oe, bus_o.ctrl_oe,
            req_ready_o}, 5'h00)
    end
    @(posedge sys_clk_i);
    bus_release_req_n_i <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (bus_release_grant_n_o !== 1'b1 && n < 20);
    if (bus_release_grant_n_o !== 1'b1) bail();
    `CHK({bus_o.addr_oe, bus_o.ctrl_oe}, 2'h3)
    $display("hold test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] modes [5];
    int m;
    int i;
    int r;
    logic wd;
    logic [19:0] ad;
    modes = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    for (i = 0; i < 256; i++) exp_mem[i] = 8'(i) ^ 8'h5a;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(negedge sys_clk_i);
    `CHK({bus_o.store_strobe_low_byte_n, bus_o.store_strobe_high_byte_n, bus_o.load_strobe_n,
          bus_o.addr_latch, bus_o.area_select_n, bus_release_grant_n_o}, 9'h1df)
    for (m = 0; m < 5; m++) begin
      @(posedge sys_clk_i);
      cfg_i <= modes[m];
      for (i = 0; i < 8; i++) begin
        r = $random(seed);
        wd = r[20] & modes[m][1];
        ad = {r[19:1], r[0] & ~wd};
        xfer(1'b1, wd, r[22:21], ad, wd ? r[31:16] : {2{r[31:24]}}, {1'b0, r[25:23]});
        xfer(1'b0, wd, r[22:21], ad, 16'h0000, {1'b0, r[28:26]});
      end
      if (m == 1) hold_test();
      $display("mode %0d done", m);
    end
    conclude();
  end
endmodule
